// ===== hw/loop_lock.sv
`timescale 1ns/1ps
`include "refsw_cfg.svh"

module loop_lock #(
    parameter logic [7:0] LOCK_EDGES = `LOCK_EDGES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Loop control
    input wire logic loop_reset,
    input wire logic pd_enable,
    input wire logic ref_rise,
    input wire logic ref_valid,
    // Loop state
    output logic locked,
    output logic clk_on
);
    logic [7:0] edge_cnt;
    logic [7:0] next_edge_cnt;
    logic next_locked;
    logic next_clk_on;

    // ************************************************
    // Lock tracking against the selected reference
    // ************************************************
    always_comb begin
        next_edge_cnt = edge_cnt;
        next_locked = locked;
        next_clk_on = clk_on;
        if (loop_reset) begin
            // Counters cleared, outputs off, out of lock [R20]
            next_edge_cnt = '0;
            next_locked = 1'b0;
            next_clk_on = 1'b0;
        end else if (!pd_enable) begin
            // Detector blocked, oscillator free-runs; lock means nothing [R21]
            next_edge_cnt = '0;
            next_locked = 1'b0;
        end else begin
            // Resynchronise to the selected reference [R20]
            next_clk_on = 1'b1;
            if (!ref_valid) begin
                next_edge_cnt = '0;
                next_locked = 1'b0;
            end else if (ref_rise && edge_cnt != LOCK_EDGES) begin
                next_edge_cnt = edge_cnt + 1'b1;
            end
            if (ref_valid && edge_cnt == LOCK_EDGES) begin
                next_locked = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            edge_cnt <= '0;
            locked <= 1'b0;
            clk_on <= 1'b0;
        end else begin
            edge_cnt <= next_edge_cnt;
            locked <= next_locked;
            clk_on <= next_clk_on;
        end
    end
endmodule

// ===== hw/pll_ref_clock_switchover.sv
`timescale 1ns/1ps
`include "refsw_cfg.svh"

// What this block does
// R1 - Automatic mode swaps to the other input whenever the current one stops, repeatedly.
// R2 - Outside party keeps both inputs running, periods within a factor of two.
// R3 - No switchover when both inputs are stopped; failure flags then undefined.
// R4 - Automatic modes raise an input's failure flag once sensing sees it stopped.
// R5 - Above twenty percent frequency difference only the selected indicator is trustworthy.
// R6 - Drive an indicator showing which input feeds the loop.
// R7 - After about two idle cycles, flag the input and move the select.
// R8 - Automatic swap takes effect on a falling edge of the available input.
// R9 - Override mode accepts the switch request for widely differing references.
// R10 - Request gates the reference at old falling edge, swaps at new falling edge.
// R11 - Manual swap between healthy inputs toggles indicator, raises no failure flag.
// R12 - Only a rising request edge switches; each new rising edge repeats it.
// R13 - Both switch kinds wait until the target input is available.
// R14 - Primary input is selected after reset.
// R15 - Controller holds the request at least three reference cycles, then releases.
// R16 - With unequal frequencies, hold three cycles of the slower reference.
// R17 - Controller raises the request only while both inputs are running.
// R18 - Controller resets the loop at least 10 ns after switching, awaits lock.
// R19 - Controller may use failure flags to disable the detector during switchover.
// R20 - Loop reset clears counters, forces outputs off, drops lock, then resynchronises.
// R21 - Detector disabled lets the oscillator free-run; lock is meaningless.
// R22 - Switchover mode is static and may not change while the loop runs.
module pll_ref_clock_switchover
    import refsw_pkg::*;
#(
    parameter int SENSE_W = 16,
    parameter logic [7:0] LOCK_EDGES = `LOCK_EDGES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Reference pins
    input wire logic primary_ref_input,
    input wire logic backup_ref_input,
    // Core logic control
    input wire logic switch_req,
    input wire logic loop_reset,
    input wire logic pd_enable,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Status
    output logic primary_bad,
    output logic backup_bad,
    output logic active_ref,
    output logic mux_select,
    output logic ref_clk_out,
    output logic loop_locked,
    output logic loop_clk_on
);
    import refsw_pkg::*;

    logic [1:0] lvl;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] bad;
    logic locked_w;
    logic clk_on_w;

    mode_t mode;
    state_t state;
    logic sel;
    logic gate_on;
    logic req_d;
    mode_t next_mode;
    state_t next_state;
    logic next_sel;
    logic next_gate_on;
    logic next_primary_bad;
    logic next_backup_bad;
    logic next_ref_clk_out;
    logic [31:0] next_rdata;
    logic req_edge;
    logic auto_on;
    logic manual_on;
    logic cur_bad;
    logic alt_bad;
    logic cur_fall;
    logic alt_fall;

    // ************************************************
    // Clock sensing of the two references
    // ************************************************
    ref_sense #(
        .CNT_W(SENSE_W)
    ) u_sense_primary (
        .clk(clk),
        .srst(srst),
        .ref_pin(primary_ref_input),
        .ref_level(lvl[0]),
        .ref_rise(rise[0]),
        .ref_fall(fall[0]),
        .ref_bad(bad[0])
    );

    ref_sense #(
        .CNT_W(SENSE_W)
    ) u_sense_backup (
        .clk(clk),
        .srst(srst),
        .ref_pin(backup_ref_input),
        .ref_level(lvl[1]),
        .ref_rise(rise[1]),
        .ref_fall(fall[1]),
        .ref_bad(bad[1])
    );

    // ************************************************
    // Loop reset, detector enable and lock
    // ************************************************
    loop_lock #(
        .LOCK_EDGES(LOCK_EDGES)
    ) u_lock (
        .clk(clk),
        .srst(srst),
        .loop_reset(loop_reset),
        .pd_enable(pd_enable),
        .ref_rise(rise[sel]),
        .ref_valid(gate_on && !bad[sel]),
        .locked(locked_w),
        .clk_on(clk_on_w)
    );

    // ************************************************
    // Switchover state machine
    // ************************************************
    always_comb begin
        auto_on = (mode == MODE_AUTO) || (mode == MODE_OVERRIDE);
        manual_on = (mode == MODE_MANUAL) || (mode == MODE_OVERRIDE);
        req_edge = switch_req && !req_d; // [R12]
        cur_bad = bad[sel];
        alt_bad = bad[~sel];
        cur_fall = fall[sel];
        alt_fall = fall[~sel];
        next_state = state;
        next_sel = sel;
        next_gate_on = gate_on;
        case (state)
            ST_RUN: begin
                if (manual_on && req_edge) begin
                    // Manual request wins over automatic sensing [R9] [R12]
                    next_state = ST_GATE;
                end else if (auto_on && cur_bad && !alt_bad) begin
                    // Old input is dead, so no falling edge to gate on [R1] [R3] [R7]
                    next_gate_on = 1'b0;
                    next_state = ST_MUX;
                end
            end
            ST_GATE: begin
                if (cur_fall || cur_bad) begin
                    next_gate_on = 1'b0; // [R10]
                    next_state = ST_MUX;
                end
            end
            ST_MUX: begin
                // Wait for the target to run, then swap on its falling edge [R8] [R10] [R13]
                if (alt_fall && !alt_bad) begin
                    next_sel = ~sel;
                    next_gate_on = 1'b1;
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;
                next_sel = 1'b0;
                next_gate_on = 1'b1;
            end
        endcase
    end

    // ************************************************
    // Status outputs
    // ************************************************
    always_comb begin
        // Flags carry sensing only in automatic modes; a manual swap raises none [R4] [R11]
        // Meaning is lost beyond a twenty percent mismatch [R5]
        next_primary_bad = auto_on && bad[0];
        next_backup_bad = auto_on && bad[1];
        // Glitch-free gated reference towards the loop counters [R10]
        next_ref_clk_out = gate_on && lvl[next_sel] && clk_on_w;
    end

    // ************************************************
    // Register port
    // ************************************************
    always_comb begin
        next_mode = mode;
        // Mode only changes while the loop is held in reset [R22]
        if (wr && addr == `REG_CTRL && loop_reset) begin
            case (wdata[`CTRL_MODE_LO +: 2])
                `MODE_AUTO: next_mode = MODE_AUTO;
                `MODE_MANUAL: next_mode = MODE_MANUAL;
                `MODE_OVERRIDE: next_mode = MODE_OVERRIDE;
                default: next_mode = mode;
            endcase
        end
        next_rdata = '0;
        if (rd) begin
            case (addr)
                `REG_CTRL: begin
                    next_rdata[`CTRL_MODE_LO +: 2] = mode;
                end
                `REG_STATUS: begin
                    next_rdata[`STAT_BAD0] = primary_bad;
                    next_rdata[`STAT_BAD1] = backup_bad;
                    next_rdata[`STAT_ACTIVE] = active_ref;
                    next_rdata[`STAT_LOCKED] = loop_locked;
                    next_rdata[`STAT_CLK_ON] = loop_clk_on;
                    next_rdata[`STAT_STATE_LO +: 3] = state;
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    // ************************************************
    // Registers
    // ************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            mode <= mode_t'(`MODE_RESET);
            state <= ST_RUN;
            sel <= 1'b0; // [R14]
            gate_on <= 1'b1;
            req_d <= 1'b0;
            rdata <= '0;
            primary_bad <= 1'b0;
            backup_bad <= 1'b0;
            active_ref <= 1'b0;
            mux_select <= 1'b0;
            ref_clk_out <= 1'b0;
            loop_locked <= 1'b0;
            loop_clk_on <= 1'b0;
        end else begin
            mode <= next_mode;
            state <= next_state;
            sel <= next_sel;
            gate_on <= next_gate_on;
            req_d <= switch_req;
            rdata <= next_rdata;
            primary_bad <= next_primary_bad;
            backup_bad <= next_backup_bad;
            active_ref <= next_sel; // [R6] [R11]
            mux_select <= next_sel; // [R7]
            ref_clk_out <= next_ref_clk_out;
            loop_locked <= locked_w;
            loop_clk_on <= clk_on_w;
        end
    end
endmodule

// ===== hw/ref_sense.sv
`timescale 1ns/1ps
`include "refsw_cfg.svh"

module ref_sense #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Reference pin
    input wire logic ref_pin,
    // Sensed state
    output logic ref_level,
    output logic ref_rise,
    output logic ref_fall,
    output logic ref_bad
);
    logic s1;
    logic s2;
    logic s3;
    logic [CNT_W-1:0] idle_cnt;
    logic [CNT_W-1:0] period;
    logic next_level;
    logic next_rise;
    logic next_fall;
    logic next_bad;
    logic [CNT_W-1:0] next_idle_cnt;
    logic [CNT_W-1:0] next_period;
    logic [CNT_W:0] limit;

    // ************************************************
    // Edge detection and loss-of-clock sensing
    // ************************************************
    always_comb begin
        next_level = ref_level;
        next_rise = 1'b0;
        next_fall = 1'b0;
        next_period = period;
        next_bad = ref_bad;
        limit = (period == '0) ? {1'b0, CNT_W'(`SENSE_IDLE_MAX)}
                               : (CNT_W + 1)'({1'b0, period} * `SENSE_PERIOD_MULT);
        next_idle_cnt = (&idle_cnt) ? idle_cnt : idle_cnt + 1'b1;
        // A change counts once the second and third stages agree
        if (s2 == s3 && s3 != ref_level) begin
            next_level = s3;
            next_rise = s3;
            next_fall = ~s3;
            next_bad = 1'b0;
            next_idle_cnt = '0;
            if (s3) begin
                next_period = idle_cnt;
            end
        end else if ({1'b0, idle_cnt} > limit) begin
            // Idle for about two of its own half periods [R4] [R7]
            next_bad = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            ref_level <= 1'b0;
            ref_rise <= 1'b0;
            ref_fall <= 1'b0;
            ref_bad <= 1'b0;
            idle_cnt <= '0;
            period <= '0;
        end else begin
            s1 <= ref_pin;
            s2 <= s1;
            s3 <= s2;
            ref_level <= next_level;
            ref_rise <= next_rise;
            ref_fall <= next_fall;
            ref_bad <= next_bad;
            idle_cnt <= next_idle_cnt;
            period <= next_period;
        end
    end
endmodule

// ===== hw/refsw_cfg.svh
`ifndef REFSW_CFG_SVH
`define REFSW_CFG_SVH

// Switchover modes
`define MODE_AUTO 2'h0
`define MODE_MANUAL 2'h1
`define MODE_OVERRIDE 2'h2
`define MODE_RESET `MODE_AUTO

// One-hot switchover states
`define ST_RUN 3'h1
`define ST_GATE 3'h2
`define ST_MUX 3'h4

// Register map (byte addresses)
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4

// Field positions
`define CTRL_MODE_LO 0
`define STAT_BAD0 0
`define STAT_BAD1 1
`define STAT_ACTIVE 2
`define STAT_LOCKED 3
`define STAT_CLK_ON 4
`define STAT_STATE_LO 8

// Clock sense: idle limit while no period has been measured yet
`define SENSE_IDLE_MAX 16'h0400
`define SENSE_PERIOD_MULT 2

// Reference rising edges needed before the loop reports lock
`define LOCK_EDGES 8'h40

`endif

// ===== hw/refsw_pkg.sv
`include "refsw_cfg.svh"

package refsw_pkg;

    typedef enum logic [1:0] {
        MODE_AUTO = `MODE_AUTO,
        MODE_MANUAL = `MODE_MANUAL,
        MODE_OVERRIDE = `MODE_OVERRIDE
    } mode_t;

    typedef enum logic [2:0] {
        ST_RUN = `ST_RUN,
        ST_GATE = `ST_GATE,
        ST_MUX = `ST_MUX
    } state_t;

endpackage

// ===== test/pll_ref_clock_switchover_props.sv
`timescale 1ns/1ps
`include "refsw_cfg.svh"

module pll_ref_clock_switchover_props
    import refsw_pkg::*;
#(
    parameter int SENSE_W = 16,
    parameter logic [7:0] LOCK_EDGES = `LOCK_EDGES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Reference pins
    input wire logic primary_ref_input,
    input wire logic backup_ref_input,
    // Core logic control
    input wire logic switch_req,
    input wire logic loop_reset,
    input wire logic pd_enable,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    // Status
    input wire logic primary_bad,
    input wire logic backup_bad,
    input wire logic active_ref,
    input wire logic mux_select,
    input wire logic ref_clk_out,
    input wire logic loop_locked,
    input wire logic loop_clk_on
);
    // ****************************************
    // Shadow of the configured mode
    // ****************************************
    logic [1:0] mode;
    logic [1:0] next_mode;
    always_comb begin
        next_mode = mode;
        if (srst) begin
            next_mode = 2'h0;
        end else if (wr && addr == `REG_CTRL && loop_reset && wdata[1:0] != 2'h3) begin
            next_mode = wdata[1:0];
        end
    end
    always_ff @(posedge clk) begin
        mode <= next_mode;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    chk_mux_follows: assert property (mux_select == active_ref)
        else $error("mux select differs from active input");
    chk_reset_state: assert property (srst |=> !active_ref && !primary_bad && !backup_bad)
        else $error("state after reset wrong");
    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h00000000)
        else $error("read data outside read answer cycle");
    chk_loop_off: assert property (loop_reset |-> ##2 !loop_clk_on && !loop_locked)
        else $error("loop outputs not off during loop reset");
    chk_pd_lock: assert property (!pd_enable |-> ##[1:3] !loop_locked)
        else $error("lock kept with detector disabled");
    chk_prim_idle: assert property ($rose(primary_bad) |-> !$past(primary_ref_input, 4) &&
        !$past(primary_ref_input, 8))
        else $error("primary flagged while toggling");
    chk_back_idle: assert property ($rose(backup_bad) |-> !$past(backup_ref_input, 4) &&
        !$past(backup_ref_input, 8))
        else $error("backup flagged while toggling");
    chk_manual_nobad: assert property (mode == MODE_MANUAL && $past(mode) == MODE_MANUAL
        |-> !primary_bad && !backup_bad)
        else $error("failure flag in manual mode");
    chk_swap_gated: assert property ($changed(active_ref) |-> !ref_clk_out)
        else $error("input swapped while reference clock not gated");
endmodule

bind pll_ref_clock_switchover pll_ref_clock_switchover_props #(.SENSE_W(SENSE_W), .LOCK_EDGES(LOCK_EDGES)) props_i (
    .clk, .srst, .primary_ref_input, .backup_ref_input, .switch_req, .loop_reset, .pd_enable,
    .addr, .wdata, .wr, .rd, .rdata, .primary_bad, .backup_bad, .active_ref, .mux_select,
    .ref_clk_out, .loop_locked, .loop_clk_on
);

// ===== test/pll_ref_clock_switchover_tb.sv
`timescale 1ns/1ps

module pll_ref_clock_switchover_tb;
    typedef struct packed {logic [3:0] a; logic [31:0] d; logic lr; logic [31:0] e;} row_t;
    logic clk, srst, pin_p, pin_b, run_p, run_b, switch_req, loop_reset, pd_enable, wr, rd;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, rv;
    logic primary_bad, backup_bad, active_ref, mux_select, ref_clk_out, loop_locked, loop_clk_on;
    int bad_count, n_checks;
    row_t rows [6];

    pll_ref_clock_switchover #(.LOCK_EDGES(8'h04)) pll_ref_clock_switchover_i (
        .clk(clk), .srst(srst), .primary_ref_input(pin_p), .backup_ref_input(pin_b),
        .switch_req(switch_req), .loop_reset(loop_reset), .pd_enable(pd_enable),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .primary_bad(primary_bad), .backup_bad(backup_bad), .active_ref(active_ref),
        .mux_select(mux_select), .ref_clk_out(ref_clk_out), .loop_locked(loop_locked),
        .loop_clk_on(loop_clk_on));
    ref_src ref_src_i (.run_p(run_p), .run_b(run_b), .primary_ref_input(pin_p), .backup_ref_input(pin_b));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task check_bit(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask
    task check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task set_mode(input logic [1:0] m);
        loop_reset <= 1'b1;
        wr_reg(4'h0, {30'h0, m});
        loop_reset <= 1'b0;
    endtask
    task do_reset;
        @(posedge clk);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
    endtask
    // Waits for one status output to reach a level, bounded
    task wait_sig(input int sel, input logic v, input int lim);
        logic g;
        int i;
        g = ~v;
        for (i = 0; i < lim && g !== v; i++) begin
            @(posedge clk);
            #1 g = (sel == 0) ? active_ref : (sel == 1) ? primary_bad : (sel == 2) ? backup_bad : loop_locked;
        end
        if (g !== v) begin
            bad_count++;
            $display("MISMATCH wait %0d expected %b seen %b", sel, v, g);
            print_verdict();
        end
    endtask

    initial begin
        {srst, wr, rd, switch_req, loop_reset} = 5'h1F;
        {wr, rd, switch_req, loop_reset} = 4'h0;
        {run_p, run_b, pd_enable} = 3'h7;
        addr = 4'h0;
        wdata = 32'h00000000;
        rows[0] = {4'h0, 32'h00000001, 1'b1, 32'h00000001};
        rows[1] = {4'h0, 32'h00000002, 1'b1, 32'h00000002};
        rows[2] = {4'h0, 32'h00000003, 1'b1, 32'h00000002};
        rows[3] = {4'h0, 32'h00000000, 1'b0, 32'h00000002};
        rows[4] = {4'h0, 32'h00000000, 1'b1, 32'h00000000};
        rows[5] = {4'hC, 32'h00000001, 1'b1, 32'h00000000};
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd_reg(4'h4);
        check_word("status", 32'h00000100, rv & 32'h00000707);
        check_bit("active", 1'b0, active_ref);
        $display("test reset done");
        foreach (rows[k]) begin
            loop_reset <= rows[k].lr;
            wr_reg(rows[k].a, rows[k].d);
            loop_reset <= 1'b0;
            rd_reg(rows[k].a);
            check_word("ctrl", rows[k].e, rv);
        end
        $display("test registers done");
        set_mode(2'h1);
        switch_req <= 1'b1;
        wait_sig(0, 1'b1, 300);
        check_bit("pbad", 1'b0, primary_bad);
        check_bit("bbad", 1'b0, backup_bad);
        repeat (30) @(posedge clk);
        switch_req <= 1'b0;
        repeat (80) @(posedge clk);
        check_bit("active", 1'b1, active_ref);
        switch_req <= 1'b1;
        wait_sig(0, 1'b0, 300);
        repeat (30) @(posedge clk);
        switch_req <= 1'b0;
        run_b <= 1'b0;
        repeat (100) @(posedge clk);
        switch_req <= 1'b1;
        repeat (200) @(posedge clk);
        check_bit("active", 1'b0, active_ref);
        run_b <= 1'b1;
        wait_sig(0, 1'b1, 300);
        switch_req <= 1'b0;
        $display("test manual done");
        do_reset();
        set_mode(2'h2);
        switch_req <= 1'b1;
        wait_sig(0, 1'b1, 300);
        switch_req <= 1'b0;
        $display("test override done");
        do_reset();
        repeat (100) @(posedge clk);
        run_p <= 1'b0;
        wait_sig(1, 1'b1, 3000);
        wait_sig(0, 1'b1, 300);
        run_p <= 1'b1;
        repeat (200) @(posedge clk);
        run_b <= 1'b0;
        wait_sig(0, 1'b0, 3000);
        run_b <= 1'b1;
        repeat (200) @(posedge clk);
        run_b <= 1'b0;
        wait_sig(2, 1'b1, 3000);
        run_p <= 1'b0;
        repeat (2500) @(posedge clk);
        check_bit("active", 1'b0, active_ref);
        {run_p, run_b} <= 2'h3;
        $display("test auto done");
        do_reset();
        loop_reset <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check_bit("clk_on", 1'b0, loop_clk_on);
        loop_reset <= 1'b0;
        wait_sig(3, 1'b1, 400);
        pd_enable <= 1'b0;
        repeat (4) @(posedge clk);
        #1 check_bit("locked", 1'b0, loop_locked);
        pd_enable <= 1'b1;
        $display("test loop done");
        print_verdict();
    end
endmodule

// ===== test/ref_src.sv
`timescale 1ns/1ps

module ref_src #(
    parameter int HALF_P = 200,
    parameter int HALF_B = 180
) (
    // Run controls
    input wire logic run_p,
    input wire logic run_b,
    // Reference clocks, held low while stopped
    output logic primary_ref_input,
    output logic backup_ref_input
);
    // Periods within a factor of two, edges off the system clock rising edges
    initial begin
        primary_ref_input = 1'b0;
        forever begin
            #HALF_P;
            primary_ref_input = run_p ? ~primary_ref_input : 1'b0;
        end
    end
    initial begin
        backup_ref_input = 1'b0;
        forever begin
            #HALF_B;
            backup_ref_input = run_b ? ~backup_ref_input : 1'b0;
        end
    end
endmodule
